// [hdl/override_consts.svh]
/*
 * Register offsets, reset values, field positions and limits of the
 * force-on and fault-log register bank.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef OVERRIDE_CONSTS_SVH
`define OVERRIDE_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFF_BREAKER_TRIP_LOG 8'h5f
`define OFF_UNDERVOLTAGE_LOG 8'h63
`define OFF_OVERVOLTAGE_LOG 8'h64
`define OFF_OVERCURRENT_LOG 8'h65
`define OFF_UNLOCK_KEY 8'h67
`define OFF_OVERRIDE_SET 8'h68
`define OFF_POST_TRIGGER_DELAY 8'h72

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_LOG 8'h00
`define RST_UNLOCK_KEY 8'h00
`define RST_OVERRIDE_SET 4'h0
`define RST_POST_TRIGGER_DELAY 6'h19

// ----------------------------------------------------------------------
// fields and limits
// ----------------------------------------------------------------------
`define UNLOCK_CODE 8'ha5
`define LOG_CRITICAL_LSB 4
`define DELAY_WIDTH 6
`define DELAY_MAX 6'h32

`endif

// [hdl/override_pkg.sv]
/*
 * Types shared by the register bank and its helpers.
 * Assumes override_consts.svh is on the include path.
 */
`include "override_consts.svh"

package override_pkg;

   typedef logic [7:0] reg_byte_t;
   typedef logic [`DELAY_WIDTH-1:0] delay_t;

   typedef enum logic [1:0] {
      BUF_RECORD = 2'b00,
      BUF_POST = 2'b01,
      BUF_HALT = 2'b10
   } buffer_state_e;

endpackage

// [hdl/sticky_log_if.sv]
/*
 * Carrier between the register bank and one sticky event log.
 * Assumes one owner module holds the log bits.
 */
`timescale 1ns/100ps

interface sticky_log_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] set;
   logic [WIDTH-1:0] keep;
   logic [WIDTH-1:0] log;
   modport owner (input set, input keep, output log);
   modport user (output set, output keep, input log);
endinterface

// [hdl/sticky_log.sv]
/*
 * One sticky event log: bits latch on set, clear where keep is low.
 * Assumes a single clock and synchronous active-low reset.
 */
`timescale 1ns/100ps

module sticky_log (
   input wire logic clock,
   input wire logic rst_n,
   sticky_log_if.owner port
);
   import override_pkg::*;

   // ----------------------------------------------------------------------
   // log storage, set wins over clear
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         port.log <= '0;
      end else begin
         port.log <= (port.log & port.keep) | port.set;
      end
   end

   set_wins_a: assert property (@(posedge clock) disable iff (!rst_n)
      1 |=> ((port.log & $past(port.set)) == $past(port.set)))
      else $error("log bit lost its set");

   hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      1 |=> ((port.log & $past(port.log & port.keep))
            == $past(port.log & port.keep)))
      else $error("log bit dropped without a clear");

endmodule // sticky_log

// [hdl/buffer_stop.sv]
/*
 * Post-trigger sample counter of one channel's capture buffer.
 * Assumes sample_tick pulses once per sample and shutdown is a pulse.
 */
`timescale 1ns/100ps
`include "override_consts.svh"

module buffer_stop (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sample_tick,
   input wire logic shutdown,
   input wire logic rearm,
   input wire override_pkg::delay_t delay,
   output logic store
);
   import override_pkg::*;

   buffer_state_e state;
   buffer_state_e next_state;
   delay_t count;
   delay_t next_count;
   delay_t limited;

   // values above the top of range are held at it
   assign limited = (delay > `DELAY_MAX) ? `DELAY_MAX : delay;

   // ----------------------------------------------------------------------
   // state machine
   // ----------------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         BUF_RECORD: begin
            if (shutdown) begin
               next_count = limited;
               next_state = (limited == '0) ? BUF_HALT : BUF_POST;
            end
         end
         BUF_POST: begin
            if (sample_tick) begin
               next_count = count - 1'b1;
               if (count == 6'h01) begin
                  next_state = BUF_HALT;
               end
            end
         end
         default: begin
            next_state = BUF_HALT;
         end
      endcase
      if (rearm) begin
         next_state = BUF_RECORD;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= BUF_RECORD;
         count <= '0;
         store <= 1'b1;
      end else begin
         state <= next_state;
         count <= next_count;
         store <= (next_state != BUF_HALT);
      end
   end

   zero_delay_a: assert property (@(posedge clock) disable iff (!rst_n)
      (state == BUF_RECORD && shutdown && limited == '0 && !rearm)
      |=> !store)
      else $error("zero delay did not stop the buffer");

   halt_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      (state == BUF_HALT && !rearm) |=> (state == BUF_HALT && !store))
      else $error("halted buffer resumed without restart");

   post_cover: cover property (@(posedge clock) disable iff (!rst_n)
      state == BUF_POST ##1 state == BUF_HALT);

endmodule // buffer_stop

// [hdl/override_fault_bank.sv]
/*
 * Force-on override, capture-buffer stop delay and fault logs of a
 * four-channel supply controller, with channel enable, trip and attention
 * outputs.
 * Assumes a serial register engine that gives one-cycle read and write
 * strobes with a byte address, and comparator and breaker inputs that are
 * synchronous to clock.
 */
//
// Function
// - an active override bit turns its channel on, whatever pin and enables say.
// - forced channels keep logging but never shut down on any fault.
// - override acts only while the unlock key holds 0xa5.
// - with a wrong key, writing ones to override bits changes nothing.
// - override register 0x68, bits 3..0 per channel, upper bits zero, reset 0.
// - stop-delay register 0x72, six-bit count, reset 0x19, top bits zero.
// - buffer records that many more samples after shutdown, range 0 to 50.
// - comparator violations set the matching channel bit in their log.
// - undervoltage log 0x63, warnings bits 3..0, critical bits 7..4.
// - overvoltage log 0x64, warnings bits 3..0, critical bits 7..4.
// - overcurrent warning log 0x65, one bit per channel in bits 3..0.
// - slow and fast breaker trips latch into their own eight-bit log.
// - each trip pin signals only breaker shutdowns of its channel.
// - attention pin asserts whenever any logged condition needs the host.
// - attention pin, active low, is the NOR of all four logs.
// - breaker bits stay until written zero or channel restarted.
//
`timescale 1ns/100ps
`include "override_consts.svh"

module override_fault_bank #(
   parameter int NCH = 4
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire override_pkg::reg_byte_t reg_addr,
   input wire override_pkg::reg_byte_t reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output override_pkg::reg_byte_t reg_rdata,
   input wire logic [NCH-1:0] on_pin,
   input wire logic [NCH-1:0] channel_enable_first_bit,
   input wire logic [NCH-1:0] channel_enable_second_bit,
   input wire logic [NCH-1:0] undervoltage_warning_bit,
   input wire logic [NCH-1:0] undervoltage_critical_bit,
   input wire logic [NCH-1:0] overvoltage_warning_bit,
   input wire logic [NCH-1:0] overvoltage_critical_bit,
   input wire logic [NCH-1:0] overcurrent_warning_bit,
   input wire logic [NCH-1:0] slow_trip,
   input wire logic [NCH-1:0] fast_trip,
   input wire logic [NCH-1:0] critical_shutdown,
   input wire logic sample_tick,
   output logic [NCH-1:0] channel_on,
   output logic [NCH-1:0] trip_out,
   output logic [NCH-1:0] trip_oe_n,
   output logic alert_out,
   output logic alert_oe_n,
   output logic [NCH-1:0] buffer_store
);
   import override_pkg::*;

   if (NCH != 4) begin : g_nch_check
      $error("register layout serves exactly four channels");
   end

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic reg_byte_t pack_pair(input logic [3:0] hi,
                                           input logic [3:0] lo);
      pack_pair = {hi, lo};
   endfunction

   // ----------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------
   reg_byte_t unlock_key;
   logic [NCH-1:0] channel_override_bit;
   delay_t post_delay;
   logic [NCH-1:0] request_q;
   logic [NCH-1:0] shut_latched;
   logic [NCH-1:0] tripped;
   logic [NCH-1:0] next_tripped;
   logic [NCH-1:0] next_shut;
   reg_byte_t next_rdata;

   sticky_log_if #(.WIDTH(8)) uv_if ();
   sticky_log_if #(.WIDTH(8)) ov_if ();
   sticky_log_if #(.WIDTH(8)) oc_if ();
   sticky_log_if #(.WIDTH(8)) bt_if ();

   // ----------------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------------
   wire hit_bt = (reg_addr == `OFF_BREAKER_TRIP_LOG);
   wire hit_uv = (reg_addr == `OFF_UNDERVOLTAGE_LOG);
   wire hit_ov = (reg_addr == `OFF_OVERVOLTAGE_LOG);
   wire hit_oc = (reg_addr == `OFF_OVERCURRENT_LOG);
   wire hit_key = (reg_addr == `OFF_UNLOCK_KEY);
   wire hit_ovr = (reg_addr == `OFF_OVERRIDE_SET);
   wire hit_dly = (reg_addr == `OFF_POST_TRIGGER_DELAY);

   // ----------------------------------------------------------------------
   // channel control
   // ----------------------------------------------------------------------
   wire unlocked = (unlock_key == `UNLOCK_CODE);
   wire [NCH-1:0] force_active =
      channel_override_bit & {NCH{unlocked}};
   wire [NCH-1:0] request = on_pin & channel_enable_first_bit
      & channel_enable_second_bit;
   wire [NCH-1:0] restart = request & ~request_q;
   wire [NCH-1:0] breaker_hit = slow_trip | fast_trip;
   // forced channels ignore every shutdown cause
   wire [NCH-1:0] shut_set = (breaker_hit | critical_shutdown)
      & channel_on & ~force_active;
   wire [NCH-1:0] breaker_shut = breaker_hit & channel_on
      & ~force_active;
   wire [NCH-1:0] next_on = force_active
      | (request & ~next_shut);

   // latched shutdown clears when the channel is turned off
   assign next_shut = (shut_latched & request) | shut_set;
   // trip pin clears when the channel is turned off
   assign next_tripped = (tripped & request) | breaker_shut;

   // ----------------------------------------------------------------------
   // log sources and clears
   // ----------------------------------------------------------------------
   assign uv_if.set = pack_pair(undervoltage_critical_bit,
      undervoltage_warning_bit);
   assign ov_if.set = pack_pair(overvoltage_critical_bit,
      overvoltage_warning_bit);
   assign oc_if.set = {4'h0, overcurrent_warning_bit};
   assign bt_if.set = pack_pair(slow_trip, fast_trip);
   // comparator logs clear on read
   assign uv_if.keep = (reg_read && hit_uv) ? 8'h00 : 8'hff;
   assign ov_if.keep = (reg_read && hit_ov) ? 8'h00 : 8'hff;
   assign oc_if.keep = (reg_read && hit_oc) ? 8'h00 : 8'hff;
   // breaker log clears where a zero is written, or on restart
   assign bt_if.keep = ((reg_write && hit_bt) ? reg_wdata : 8'hff)
      & ~pack_pair(restart, restart);

   wire any_logged = (|uv_if.log) | (|ov_if.log) | (|oc_if.log)
      | (|bt_if.log);

   sticky_log u_uv_log (.clock(clock), .rst_n(rst_n), .port(uv_if));
   sticky_log u_ov_log (.clock(clock), .rst_n(rst_n), .port(ov_if));
   sticky_log u_oc_log (.clock(clock), .rst_n(rst_n), .port(oc_if));
   sticky_log u_bt_log (.clock(clock), .rst_n(rst_n), .port(bt_if));

   // ----------------------------------------------------------------------
   // capture buffer stop delay per channel
   // ----------------------------------------------------------------------
   for (genvar ch = 0; ch < NCH; ch++) begin : g_buf
      buffer_stop u_stop (
         .clock(clock),
         .rst_n(rst_n),
         .sample_tick(sample_tick),
         .shutdown(shut_set[ch] & ~shut_latched[ch]),
         .rearm(restart[ch]),
         .delay(post_delay),
         .store(buffer_store[ch])
      );
   end

   // ----------------------------------------------------------------------
   // read mux, unmapped reads return zero
   // ----------------------------------------------------------------------
   always_comb begin
      if (hit_bt) begin
         next_rdata = bt_if.log;
      end else if (hit_uv) begin
         next_rdata = uv_if.log;
      end else if (hit_ov) begin
         next_rdata = ov_if.log;
      end else if (hit_oc) begin
         next_rdata = {4'h0, oc_if.log[3:0]};
      end else if (hit_key) begin
         next_rdata = unlock_key;
      end else if (hit_ovr) begin
         next_rdata = {4'h0, channel_override_bit};
      end else if (hit_dly) begin
         next_rdata = {2'b00, post_delay};
      end else begin
         next_rdata = 8'h00;
      end
   end

   // ----------------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         unlock_key <= `RST_UNLOCK_KEY;
         channel_override_bit <= `RST_OVERRIDE_SET;
         post_delay <= `RST_POST_TRIGGER_DELAY;
      end else if (reg_write) begin
         if (hit_key) begin
            unlock_key <= reg_wdata;
         end
         if (hit_ovr) begin
            // locked: only clears get through
            channel_override_bit <= unlocked ? reg_wdata[3:0]
               : (channel_override_bit & reg_wdata[3:0]);
         end
         if (hit_dly) begin
            post_delay <= reg_wdata[5:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // channel state and pins
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         request_q <= '0;
         shut_latched <= '0;
         tripped <= '0;
         channel_on <= '0;
         trip_oe_n <= '1;
         trip_out <= '0;
         alert_oe_n <= 1'b1;
         alert_out <= 1'b0;
         reg_rdata <= 8'h00;
      end else begin
         request_q <= request;
         shut_latched <= next_shut;
         tripped <= next_tripped;
         channel_on <= next_on;
         trip_oe_n <= ~next_tripped;
         trip_out <= '0;
         alert_oe_n <= ~any_logged;
         alert_out <= 1'b0;
         if (reg_read) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   force_on_a: assert property (
      1 |=> ((channel_on & $past(force_active)) == $past(force_active)))
      else $error("forced channel not on");

   forced_shut_a: assert property (
      (force_active != '0) |=> ((shut_latched & $past(force_active))
      == ($past(shut_latched) & $past(request) & $past(force_active))))
      else $error("forced channel latched a shutdown");

   key_gate_a: assert property (
      (!unlocked && request == '0) |=> (channel_on == '0))
      else $error("override acted without the key");

   locked_write_a: assert property (
      (reg_write && hit_ovr && !unlocked)
      |=> ((channel_override_bit & ~$past(channel_override_bit)) == '0))
      else $error("locked write set an override bit");

   delay_read_a: assert property (
      (reg_read && hit_dly) |=> (reg_rdata[7:6] == 2'b00
      && reg_rdata[5:0] == $past(post_delay)))
      else $error("stop delay read wrong");

   uv_clear_a: assert property (
      (reg_read && hit_uv) |=> (uv_if.log == $past(uv_if.set)))
      else $error("undervoltage log not cleared by read");

   slow_log_a: assert property (
      slow_trip[0] |=> bt_if.log[4])
      else $error("slow trip not logged");

   alert_a: assert property (
      1 |=> (alert_oe_n == $past(!((|uv_if.log) | (|ov_if.log)
      | (|oc_if.log) | (|bt_if.log)))))
      else $error("attention pin not the nor of the logs");

   trip_only_a: assert property (
      (breaker_hit == '0 && trip_oe_n == '1) |=> (trip_oe_n == '1))
      else $error("trip pin set by a non-breaker cause");

   restart_clear_a: assert property (
      (restart[0] && !fast_trip[0]) |=> !bt_if.log[0])
      else $error("restart left breaker bit set");

   forced_fault_c: cover property (
      force_active[0] && slow_trip[0] ##1 channel_on[0]);
   locked_write_c: cover property (reg_write && hit_ovr && !unlocked);
   alert_c: cover property (alert_oe_n ##1 !alert_oe_n);

endmodule // override_fault_bank

// [test/host_model.sv]
/*
 * Host model: the system controller behind the serial register engine,
 * issuing one-cycle read and write strobes with a byte address.
 * Assumes the bank takes a strobe on the rising edge of clock and
 * answers a read one cycle after that edge.
 */
`timescale 1ns/100ps
`include "override_consts.svh"

module host_model (
   input wire logic clock,
   output override_pkg::reg_byte_t reg_addr,
   output override_pkg::reg_byte_t reg_wdata,
   output logic reg_write,
   output logic reg_read,
   input wire override_pkg::reg_byte_t reg_rdata
);
   import override_pkg::*;

   // ------------------------------------------------------------------
   // idle bus
   // ------------------------------------------------------------------
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end

   // ------------------------------------------------------------------
   // register cycles
   // ------------------------------------------------------------------
   task automatic write_reg(input reg_byte_t addr, input reg_byte_t data);
      @(posedge clock);
      reg_addr <= addr;
      reg_wdata <= data;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask

   task automatic read_reg(input reg_byte_t addr, output reg_byte_t data);
      @(posedge clock);
      reg_addr <= addr;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(posedge clock);
      data = reg_rdata;
   endtask

   // key first, then the override bits
   task automatic force_channels(input logic [3:0] mask);
      write_reg(`OFF_UNLOCK_KEY, `UNLOCK_CODE);
      write_reg(`OFF_OVERRIDE_SET, {4'h0, mask});
   endtask

   // stop delay kept within the legal sample range
   task automatic set_delay(input delay_t count);
      if (count > `DELAY_MAX) count = `DELAY_MAX;
      write_reg(`OFF_POST_TRIGGER_DELAY, {2'b00, count});
   endtask
endmodule // host_model

// [test/override_fault_bank_test.sv]
/*
 * Self-checking bench of the override and fault-log register bank.
 * Assumes host_model on the register port and the design files compiled
 * first; all other inputs are driven here.
 */
`timescale 1ns/100ps
`include "override_consts.svh"

module override_fault_bank_test;
   import override_pkg::*;

   // ------------------------------------------------------------------
   // stimulus and wiring
   // ------------------------------------------------------------------
   localparam int TIMEOUT = 5000;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   reg_byte_t reg_addr, reg_wdata, reg_rdata, got, exp, addr;
   logic reg_write, reg_read, sample_tick = 1'b0;
   logic [3:0] on_pin = 4'h0, en1 = 4'h0, en2 = 4'h0;
   logic [3:0] slow_trip = 4'h0, fast_trip = 4'h0, crit = 4'h0;
   logic [3:0] cmp [5] = '{default: 4'h0};
   logic [3:0] channel_on, trip_out, trip_oe_n, buffer_store;
   logic alert_out, alert_oe_n;
   int mismatches = 0;
   int checks = 0;
   int cycle_count = 0;
   int ch;

   always #5 clock = ~clock;

   host_model host (.clock(clock), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata));

   override_fault_bank #(.NCH(4)) DUT (.clock(clock), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .on_pin(on_pin),
      .channel_enable_first_bit(en1), .channel_enable_second_bit(en2),
      .undervoltage_warning_bit(cmp[0]), .undervoltage_critical_bit(cmp[1]),
      .overvoltage_warning_bit(cmp[2]), .overvoltage_critical_bit(cmp[3]),
      .overcurrent_warning_bit(cmp[4]), .slow_trip(slow_trip),
      .fast_trip(fast_trip), .critical_shutdown(crit),
      .sample_tick(sample_tick), .channel_on(channel_on),
      .trip_out(trip_out), .trip_oe_n(trip_oe_n), .alert_out(alert_out),
      .alert_oe_n(alert_oe_n), .buffer_store(buffer_store));

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic check_byte(input string what, input reg_byte_t e,
      input reg_byte_t g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic check_pins(input string what, input logic [3:0] e,
      input logic [3:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic sample_pulse();
      @(posedge clock);
      sample_tick <= 1'b1;
      @(posedge clock);
      sample_tick <= 1'b0;
   endtask

   task automatic restart();
      @(posedge clock);
      on_pin <= 4'h0;
      cycles(2);
      on_pin <= 4'hf;
      cycles(3);
   endtask

   task automatic trip_pulse(input logic [3:0] s, input logic [3:0] f,
      input logic [3:0] c);
      @(posedge clock);
      slow_trip <= s;
      fast_trip <= f;
      crit <= c;
      @(posedge clock);
      slow_trip <= 4'h0;
      fast_trip <= 4'h0;
      crit <= 4'h0;
      cycles(3);
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycle_count <= cycle_count + 1;
      if (cycle_count == TIMEOUT) begin
         mismatches++;
         conclude();
      end
   end

   // ------------------------------------------------------------------
   // tests
   // ------------------------------------------------------------------
   initial begin
      cycles(5);
      rst_n <= 1'b1;
      cycles(1);
      check_pins("store after reset", 4'hf, buffer_store);
      check_pins("alert after reset", 4'h1, {3'b000, alert_oe_n});
      host.read_reg(8'h63, got);
      check_byte("uv log reset", 8'h00, got);
      host.read_reg(8'h64, got);
      check_byte("ov log reset", 8'h00, got);
      host.read_reg(8'h65, got);
      check_byte("oc log reset", 8'h00, got);
      host.read_reg(8'h68, got);
      check_byte("override reset", 8'h00, got);
      host.read_reg(8'h72, got);
      check_byte("delay reset", 8'h19, got);
      host.read_reg(8'h70, got);
      check_byte("unmapped read", 8'h00, got);
      // wrong key: override ones have no effect
      host.write_reg(8'h67, 8'h5a);
      host.write_reg(8'h68, 8'h0f);
      host.read_reg(8'h67, got);
      check_byte("key readback", 8'h5a, got);
      host.read_reg(8'h68, got);
      check_byte("override locked", 8'h00, got);
      check_pins("not forced", 4'h0, channel_on);
      // right key: forced on with pin and enables low
      host.force_channels(4'h5);
      cycles(3);
      check_pins("forced on", 4'h5, channel_on);
      host.write_reg(8'h68, 8'hff);
      host.read_reg(8'h68, got);
      check_byte("override upper zero", 8'h0f, got);
      host.write_reg(8'h67, 8'h00);
      host.write_reg(8'h68, 8'h05);
      cycles(3);
      check_pins("key removed", 4'h0, channel_on);
      host.write_reg(8'h68, 8'h00);
      host.read_reg(8'h68, got);
      check_byte("override cleared", 8'h00, got);
      // comparator logs, every kind
      for (int k = 0; k < 5; k++) begin
         ch = (k + 1) % 4;
         exp = 8'h01 << (ch + (k % 2) * 4);
         addr = 8'(`OFF_UNDERVOLTAGE_LOG + k / 2);
         @(posedge clock);
         cmp[k][ch] <= 1'b1;
         @(posedge clock);
         cmp[k][ch] <= 1'b0;
         cycles(3);
         check_pins("alert set", 4'h0, {3'b000, alert_oe_n});
         host.write_reg(addr, 8'h00);
         host.read_reg(addr, got);
         check_byte("log set", exp, got);
         host.read_reg(addr, got);
         check_byte("log read clear", 8'h00, got);
         cycles(2);
         check_pins("alert clear", 4'h1, {3'b000, alert_oe_n});
      end
      // breaker trips and other shutdowns
      @(posedge clock);
      on_pin <= 4'hf;
      en1 <= 4'hf;
      en2 <= 4'hf;
      cycles(3);
      check_pins("enabled", 4'hf, channel_on);
      trip_pulse(4'h2, 4'h4, 4'h8);
      check_pins("shut down", 4'h1, channel_on);
      check_pins("trip pins", 4'h9, trip_oe_n);
      check_pins("trip data", 4'h0, trip_out);
      check_pins("alert trip", 4'h0, {alert_out, 2'b00, alert_oe_n});
      host.read_reg(8'h5f, got);
      check_byte("breaker log", 8'h24, got);
      host.read_reg(8'h5f, got);
      check_byte("breaker sticky", 8'h24, got);
      host.write_reg(8'h5f, 8'hfb);
      host.read_reg(8'h5f, got);
      check_byte("breaker write zero", 8'h20, got);
      restart();
      host.read_reg(8'h5f, got);
      check_byte("breaker restart", 8'h00, got);
      check_pins("trip released", 4'hf, trip_oe_n);
      check_pins("restarted", 4'hf, channel_on);
      // forced channel keeps logging but stays on
      host.force_channels(4'h1);
      trip_pulse(4'h1, 4'h0, 4'h0);
      check_pins("forced stays on", 4'hf, channel_on);
      check_pins("forced no trip", 4'hf, trip_oe_n);
      host.read_reg(8'h5f, got);
      check_byte("forced logs", 8'h10, got);
      host.write_reg(8'h68, 8'h00);
      host.write_reg(8'h67, 8'h00);
      restart();
      // stop delay
      host.write_reg(8'h72, 8'hff);
      host.read_reg(8'h72, got);
      check_byte("delay top zero", 8'h3f, got);
      host.set_delay(6'h03);
      host.read_reg(8'h72, got);
      check_byte("delay readback", 8'h03, got);
      trip_pulse(4'h1, 4'h0, 4'h0);
      sample_pulse();
      sample_pulse();
      cycles(2);
      check_pins("still storing", 4'hf, buffer_store);
      sample_pulse();
      cycles(2);
      check_pins("stopped", 4'he, buffer_store);
      restart();
      check_pins("rearmed", 4'hf, buffer_store);
      // zero delay stops at once, top of range after fifty samples
      host.set_delay(6'h00);
      trip_pulse(4'h2, 4'h0, 4'h0);
      check_pins("zero delay stop", 4'hd, buffer_store);
      restart();
      host.set_delay(6'h32);
      trip_pulse(4'h4, 4'h0, 4'h0);
      repeat (49) sample_pulse();
      cycles(2);
      check_pins("delay 50 storing", 4'hf, buffer_store);
      sample_pulse();
      cycles(2);
      check_pins("delay 50 stopped", 4'hb, buffer_store);
      conclude();
   end
endmodule // override_fault_bank_test
